// [dv/ddr_bus_cmd_addr_decode_props.sv]
// checker for command decode and strobe behaviour
`timescale 1ns/1ns
module ddr_bus_cmd_addr_decode_props (
    input wire clk,
    input wire rst_n,
    input wire select_n,
    input wire bus_clk,
    input wire [7:0] dq_in,
    input wire dq_oe,
    input wire strobe_mask_line_out,
    input wire strobe_mask_line_oe,
    input wire need_extra_latency,
    input wire cmd_valid,
    input wire cmd_read,
    input wire cmd_reg_space,
    input wire cmd_linear,
    input wire [31:0] cmd_word_addr,
    input wire access_start,
    input wire wr_valid,
    input wire txn_end
);
    // ==========
    // reference capture of the command bytes
    logic bc_r;
    logic [47:0] sh_r;
    logic [2:0] cnt_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bc_r <= 1'b0;
            sh_r <= 48'h000000000000;
            cnt_r <= 3'h0;
        end else begin
            bc_r <= bus_clk;
            if (select_n) cnt_r <= 3'h0;
            else if (bus_clk != bc_r && cnt_r < 3'h6) begin
                sh_r <= {sh_r[39:0], dq_in};
                cnt_r <= cnt_r + 3'h1;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_SIX: assert property ($rose(cmd_valid) |-> cnt_r == 3'h6) else $error("decode before six bytes");
    AST_DIR: assert property ($rose(cmd_valid) |-> cmd_read == sh_r[47]) else $error("direction wrong");
    AST_SPACE: assert property ($rose(cmd_valid) |-> cmd_reg_space == sh_r[46]) else $error("space wrong");
    AST_BURST: assert property ($rose(cmd_valid) |-> cmd_linear == sh_r[45]) else $error("burst wrong");
    AST_ADDR: assert property ($rose(cmd_valid) |-> cmd_word_addr == {sh_r[44:16], sh_r[2:0]})
        else $error("word address wrong");
    AST_START: assert property ($rose(access_start) |-> cnt_r >= 3'h4) else $error("access started early");
    AST_END: assert property ($rose(select_n) && cmd_valid |-> ##[1:5] txn_end) else $error("no end pulse");
    AST_OE: assert property (dq_oe |-> cmd_read) else $error("data driven on write");
    AST_LAT: assert property (!select_n && strobe_mask_line_oe && !dq_oe && cnt_r != 3'h6
        |-> strobe_mask_line_out == need_extra_latency) else $error("latency flag wrong");
    AST_WR: assert property (wr_valid |-> !cmd_read && cmd_valid) else $error("stray write word");
endmodule
bind ddr_bus_cmd_addr_decode ddr_bus_cmd_addr_decode_props props (.clk, .rst_n, .select_n, .bus_clk, .dq_in,
    .dq_oe, .strobe_mask_line_out, .strobe_mask_line_oe, .need_extra_latency, .cmd_valid, .cmd_read,
    .cmd_reg_space, .cmd_linear, .cmd_word_addr, .access_start, .wr_valid, .txn_end);

// [dv/ddr_host_model.sv]
// host side model: drives select, link clock and command/data bytes
`timescale 1ns/1ns
module ddr_host_model (
    output logic select_n,
    output logic bus_clk,
    output logic [7:0] dq_in,
    output logic strobe_mask_line_in
);
    // ==========
    // bus activity
    initial begin
        select_n = 1'b1;
        bus_clk = 1'b0;
        dq_in = 8'h00;
        strobe_mask_line_in = 1'b0;
    end
    // byte set up half a phase ahead of the edge it belongs to
    task automatic put(input [7:0] b, input m);
        dq_in = b;
        strobe_mask_line_in = m;
        #40 bus_clk = ~bus_clk;
        #40;
    endtask
    task automatic txn(input [47:0] ca, input int lat, input int words, input [15:0] wd, input [1:0] wm);
        int i;
        select_n = 1'b0;
        #80;
        for (i = 0; i < 6; i++) put(ca[47-8*i -: 8], ~strobe_mask_line_in);
        for (i = 0; i < 2 * lat; i++) put(~dq_in, ~strobe_mask_line_in);
        for (i = 0; i < 2 * words; i++) begin
            if (ca[47]) put(~dq_in, ~strobe_mask_line_in);
            else put(i[0] ? wd[7:0] : wd[15:8], i[0] ? wm[0] : wm[1]);
        end
        #40 select_n = 1'b1;
        dq_in = ~dq_in;
        strobe_mask_line_in = ~strobe_mask_line_in;
        #200;
    endtask
endmodule

// [dv/tb_ddr_bus_cmd_addr_decode.sv]
// testbench for the ddr bus command/address decode block
`timescale 1ns/1ns
module tb_ddr_bus_cmd_addr_decode;
    logic clk = 1'b0, rst_n = 1'b0, need_extra_latency = 1'b0;
    logic [15:0] rd_data = 16'hC3A5, got_wd;
    logic [1:0] got_wm;
    logic [31:0] first_addr;
    logic [28:0] got_pf;
    logic [7:0] rd_a, rd_b;
    wire select_n, bus_clk, strobe_mask_line_in, dq_oe, strobe_mask_line_out, strobe_mask_line_oe, cmd_valid;
    wire cmd_read, cmd_reg_space, cmd_linear, access_start, prefetch_req, data_req, wr_valid, txn_end;
    wire [7:0] dq_in, dq_out;
    wire [31:0] cmd_word_addr, data_word_addr;
    wire [28:0] prefetch_half_page;
    wire [15:0] wr_data;
    wire [1:0] wr_mask;
    int failures = 0, checks_done = 0, n_wr = 0, n_end = 0, n_req = 0, n_txn = 0;
    ddr_bus_cmd_addr_decode #(.LATENCY(2)) dut (.clk, .rst_n, .select_n, .bus_clk, .dq_in, .dq_out, .dq_oe,
        .strobe_mask_line_in, .strobe_mask_line_out, .strobe_mask_line_oe, .need_extra_latency, .cmd_valid,
        .cmd_read, .cmd_reg_space, .cmd_linear, .cmd_word_addr, .access_start, .prefetch_half_page,
        .prefetch_req, .data_word_addr, .data_req, .rd_data, .wr_data, .wr_mask, .wr_valid, .txn_end);
    ddr_host_model host (.select_n, .bus_clk, .dq_in, .strobe_mask_line_in);
    // ==========
    // clock, monitors and checking tasks
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        if (wr_valid) begin
            got_wd <= wr_data;
            got_wm <= wr_mask;
            n_wr <= n_wr + 1;
        end
        if (txn_end) n_end <= n_end + 1;
        if (prefetch_req) got_pf <= prefetch_half_page;
        if (data_req && n_req == 0) first_addr <= data_word_addr;
        if (data_req) n_req <= n_req + 1;
        if (dq_oe && strobe_mask_line_out) rd_a <= dq_out;
        if (dq_oe && !strobe_mask_line_out) rd_b <= dq_out;
    end
    task automatic chk(input string name, input [47:0] exp, input [47:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic run(input [47:0] ca, input extra, input int words, input [15:0] wd, input [1:0] wm);
        need_extra_latency = extra;
        n_req = 0;
        host.txn(ca, extra ? 4 : 2, words, wd, wm);
        repeat (10) @(posedge clk);
        #1;
        n_txn++;
        chk("read", ca[47], cmd_read);
        chk("space", ca[46], cmd_reg_space);
        chk("linear", ca[45], cmd_linear);
        chk("addr", {ca[44:16], ca[2:0]}, cmd_word_addr);
        chk("ends", n_txn, n_end);
    endtask
    // ==========
    // scenarios
    initial begin
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        run(48'h2ABCDE12345D, 1'b0, 1, 16'hA53C, 2'b01);
        chk("wr_data", 16'hA53C, got_wd);
        chk("wr_mask", 2'b01, got_wm);
        chk("wr_cnt", 1, n_wr);
        run(48'hC12345670005, 1'b1, 2, 16'h0000, 2'b00);
        chk("rd_addr", {29'h01234567 & 29'h1FFFFFFF, 3'h5}, first_addr);
        chk("rd_word", 16'hC3A5, {rd_a, rd_b});
        run(48'hA00000010007, 1'b0, 3, 16'h0000, 2'b00);
        chk("prefetch", 29'h00000003, got_pf);
        wrap_up;
    end
    initial begin
        #200000;
        failures++;
        wrap_up;
    end
endmodule

// [src/ddr_bus_cmd_addr_decode.v]
// device-side command/address capture and read data placement for an 8-bit ddr bus
`timescale 1ns/1ns
`include "ddr_cmd_defines.vh"
module ddr_bus_cmd_addr_decode #(
    parameter LATENCY = 8
) (
    input wire clk,
    input wire rst_n,
    input wire select_n,
    input wire bus_clk,
    input wire [7:0] dq_in,
    output reg [7:0] dq_out,
    output reg dq_oe,
    input wire strobe_mask_line_in,
    output reg strobe_mask_line_out,
    output reg strobe_mask_line_oe,
    input wire need_extra_latency,
    output reg cmd_valid,
    output reg cmd_read,
    output reg cmd_reg_space,
    output reg cmd_linear,
    output reg [31:0] cmd_word_addr,
    output reg access_start,
    output reg [28:0] prefetch_half_page,
    output reg prefetch_req,
    output reg [31:0] data_word_addr,
    output reg data_req,
    input wire [15:0] rd_data,
    output reg [15:0] wr_data,
    output reg [1:0] wr_mask,
    output reg wr_valid,
    output reg txn_end
);
// ==============================================
// reset release and pin synchronisers
reg [1:0] rst_sync_r;
wire rst_n_int = rst_sync_r[1];
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        rst_sync_r <= 2'b00;
    end else begin
        rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
end
wire [10:0] pins_s;
// select travels inverted so the cleared synchroniser reads as an idle, deselected bus
ddr_sync2 #(.W(11)) u_sync (
    .clk(clk),
    .rst_n(rst_n_int),
    .d({~select_n, bus_clk, strobe_mask_line_in, dq_in}),
    .q(pins_s)
);
wire sel_n_s = ~pins_s[10];
wire ck_s = pins_s[9];
wire mask_s = pins_s[8];
wire [7:0] dq_s = pins_s[7:0];
// ==============================================
// edge detection on the sampled link clock and select
reg ck_d_r;
reg sel_n_d_r;
always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
        ck_d_r <= 1'b0;
        sel_n_d_r <= 1'b1;
    end else begin
        ck_d_r <= ck_s;
        sel_n_d_r <= sel_n_s;
    end
end
wire ck_rise = ck_s & ~ck_d_r;
wire ck_fall = ~ck_s & ck_d_r;
wire ck_edge = ck_rise | ck_fall;
// select falls with the clock idle low
wire sel_start = sel_n_d_r & ~sel_n_s & ~ck_s;
wire sel_end = ~sel_n_d_r & sel_n_s;
// ==============================================
// transaction state machine
reg [2:0] state_r;
reg [2:0] state_nxt;
reg [2:0] byte_cnt_r;
reg [47:0] ca_r;
reg [7:0] lat_cnt_r;
reg byte_b_r;
reg [7:0] byte_a_r;
reg mask_a_r;
reg [2:0] half_cnt_r;
wire [47:0] ca_full = {ca_r[39:0], dq_s};
always @* begin
    state_nxt = state_r;
    case (state_r)
        `ST_IDLE: begin
            if (sel_start) begin
                state_nxt = `ST_CA;
            end
        end
        `ST_CA: begin
            if (ck_edge && byte_cnt_r == `CA_BYTES - 3'd1) begin
                state_nxt = `ST_WAIT;
            end
        end
        `ST_WAIT: begin
            if (lat_cnt_r == 8'd0 && ck_rise) begin
                state_nxt = `ST_DATA;
            end
        end
        `ST_DATA: begin
            state_nxt = `ST_DATA;
        end
        default: begin
            state_nxt = `ST_IDLE;
        end
    endcase
    if (sel_end) begin
        state_nxt = `ST_IDLE;
    end
end
wire in_data = (state_r == `ST_DATA) || (state_r == `ST_WAIT && state_nxt == `ST_DATA);
// latency counts link clock rising edges after the last command byte
// extra latency doubles the wait
localparam [7:0] LAT_BASE = LATENCY[7:0];
wire [7:0] lat_init = need_extra_latency ? {LAT_BASE[6:0], 1'b0} : LAT_BASE;
// read word placed as A/B bytes; byte A is rd_data[15:8] in both register and memory space
wire [7:0] rd_byte_a = rd_data[15:8];
wire [7:0] rd_byte_b = rd_data[7:0];
always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
        state_r <= `ST_IDLE;
        byte_cnt_r <= 3'd0;
        ca_r <= 48'h000000000000;
        lat_cnt_r <= 8'h00;
        half_cnt_r <= 3'd0;
        cmd_valid <= 1'b0;
        cmd_read <= 1'b0;
        cmd_reg_space <= 1'b0;
        cmd_linear <= 1'b0;
        cmd_word_addr <= 32'h00000000;
        access_start <= 1'b0;
        prefetch_half_page <= 29'h00000000;
        prefetch_req <= 1'b0;
        data_word_addr <= 32'h00000000;
        data_req <= 1'b0;
        txn_end <= 1'b0;
    end else begin
        state_r <= state_nxt;
        access_start <= 1'b0;
        prefetch_req <= 1'b0;
        data_req <= 1'b0;
        txn_end <= sel_end & (state_r != `ST_IDLE);
        if (sel_end) begin
            cmd_valid <= 1'b0;
        end
        case (state_r)
            `ST_IDLE: begin
                byte_cnt_r <= 3'd0;
                if (sel_start) begin
                    lat_cnt_r <= lat_init;
                end
            end
            `ST_CA: begin
                if (ck_edge) begin
                    // one byte per edge, most significant first
                    ca_r <= ca_full;
                    byte_cnt_r <= byte_cnt_r + 3'd1;
                    if (byte_cnt_r == 3'd3) begin
                        // half-page address in hand: start the access
                        access_start <= 1'b1;
                        cmd_word_addr[31:3] <= ca_full[28:0];
                    end
                    if (byte_cnt_r == `CA_BYTES - 3'd1) begin
                        cmd_valid <= 1'b1;
                        cmd_read <= ca_full[`CA_DIR_BIT];
                        cmd_reg_space <= ca_full[`CA_SPACE_BIT];
                        cmd_linear <= ca_full[`CA_BURST_BIT];
                        // bits 15..3 dropped as reserved
                        cmd_word_addr <= {ca_full[`CA_ROW_HI:`CA_ROW_LO], ca_full[`CA_COL_HI:`CA_COL_LO]};
                        data_word_addr <= {ca_full[`CA_ROW_HI:`CA_ROW_LO], ca_full[`CA_COL_HI:`CA_COL_LO]};
                        half_cnt_r <= ca_full[`CA_COL_HI:`CA_COL_LO];
                        prefetch_half_page <= ca_full[`CA_ROW_HI:`CA_ROW_LO] + 29'h00000001;
                        prefetch_req <= ca_full[`CA_BURST_BIT];
                    end
                end
            end
            `ST_WAIT: begin
                if (ck_rise && lat_cnt_r != 8'd0) begin
                    lat_cnt_r <= lat_cnt_r - 8'd1;
                end
                if (state_nxt == `ST_DATA) begin
                    data_req <= cmd_read;
                end
            end
            default: begin
            end
        endcase
        // the first data edge is taken while the state still reads ST_WAIT,
        // so the data lanes key on in_data rather than on the state alone
        if (in_data && ck_edge) begin
            if (ck_fall) begin
                data_word_addr <= data_word_addr + 32'h00000001;
                data_req <= cmd_read;
                half_cnt_r <= half_cnt_r + 3'd1;
                if (!cmd_linear) begin
                    data_word_addr[2:0] <= data_word_addr[2:0] + 3'd1;
                    data_word_addr[31:3] <= data_word_addr[31:3];
                end
                // entering a new half-page: fetch the one after it
                if (cmd_linear && half_cnt_r == 3'd7) begin
                    prefetch_half_page <= data_word_addr[31:3] + 29'h00000002;
                    prefetch_req <= 1'b1;
                end
            end
        end
    end
end
// ==============================================
// write lane: byte A waits for its byte B
always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
        byte_a_r <= 8'h00;
        mask_a_r <= 1'b0;
        byte_b_r <= 1'b0;
        wr_data <= 16'h0000;
        wr_mask <= 2'b00;
        wr_valid <= 1'b0;
    end else begin
        wr_valid <= 1'b0;
        if (in_data && ck_edge && !cmd_read) begin
            if (ck_rise) begin
                byte_a_r <= dq_s;
                mask_a_r <= mask_s;
                byte_b_r <= 1'b1;
            end else if (byte_b_r) begin
                // write word only completes on byte B
                wr_data <= {byte_a_r, dq_s};
                wr_mask <= {mask_a_r, mask_s};
                wr_valid <= 1'b1;
                byte_b_r <= 1'b0;
            end
        end
        // a cut frame leaves a lone byte A behind: drop it
        if (sel_end) begin
            byte_b_r <= 1'b0;
        end
    end
end
// ==============================================
// strobe and read data drive
always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
        dq_out <= 8'h00;
        dq_oe <= 1'b0;
        strobe_mask_line_out <= 1'b0;
        strobe_mask_line_oe <= 1'b0;
    end else begin
        if (state_r == `ST_IDLE && sel_start) begin
            // latency indication during command phase
            strobe_mask_line_out <= need_extra_latency;
            strobe_mask_line_oe <= 1'b1;
        end
        // the line is released once the last command byte is in
        if (state_r == `ST_CA && ck_edge && byte_cnt_r == `CA_BYTES - 3'd1) begin
            strobe_mask_line_oe <= 1'b0;
        end
        if (in_data && ck_edge && cmd_read) begin
            // strobe follows clock, byte A high half, byte B low half
            dq_oe <= 1'b1;
            strobe_mask_line_oe <= 1'b1;
            strobe_mask_line_out <= ck_rise;
            dq_out <= ck_rise ? rd_byte_a : rd_byte_b;
        end
        // ending the transaction always releases the bus
        if (sel_end) begin
            dq_oe <= 1'b0;
            strobe_mask_line_oe <= 1'b0;
        end
    end
end
endmodule

// [src/ddr_cmd_defines.vh]
// constants for the ddr bus command/address decode block
`ifndef DDR_CMD_DEFINES_VH
`define DDR_CMD_DEFINES_VH
`define CA_BYTES 3'd6
`define CA_DIR_BIT 47
`define CA_SPACE_BIT 46
`define CA_BURST_BIT 45
`define CA_ROW_HI 44
`define CA_ROW_LO 16
`define CA_COL_HI 2
`define CA_COL_LO 0
`define HALF_PAGE_WORDS 4'd8
`define ST_IDLE 3'd0
`define ST_CA 3'd1
`define ST_WAIT 3'd2
`define ST_DATA 3'd3
`define ST_DONE 3'd4
`define LATENCY_CYCLES 8'd6
`endif

// [src/ddr_sync2.v]
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module ddr_sync2 #(
    parameter W = 1
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
reg [W-1:0] meta_r;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        meta_r <= {W{1'b0}};
        q <= {W{1'b0}};
    end else begin
        meta_r <= d;
        q <= meta_r;
    end
end
endmodule
